/* File: rtl/ivm_vector_map.sv */
// Interrupt vector mapping: pending flags, source enables, global gate and vector selection.
//
// Function
// - Each source's condition pulse, except for the reset entry vector 0, sets its pending flag, held in this block's pending flag register.
// - Every source except the reset entry vector 0 and the non-maskable vector 1 has its own source enable bit that software writes in the source enable register.
// - A maskable source requests only while both its enable bit and its pending flag are set; vector 1 needs only its flag.
// - A request stays active until software clears its pending flag or, for a maskable source, its enable bit or the global enable; it never clears itself.
// - Maskable requests reach the CPU only while the global enable is set.
// - Vectors run from 0 to 30, one per source, each at word address twice its number.
// - Vector 0 is the reset entry and vector 1 is the non-maskable checksum scan request.
// - Vectors 2 to 7 are voltage monitor, pin change of ports A, B and C, counter count and periodic tick.
// - Vectors 8 to 16 are the timers: type A underflows, overflow and compares, then capture and control timers.
// - Vectors 17 to 23 are the three comparators and the result and window requests of both converters.
// - Vectors 24 to 30 are two-wire slave and master, SPI, serial port events and the EEPROM request.
// - The port C vector exists only with at least 20 pins and is never requested on smaller parts.
`timescale 1ns/1ps
module ivm_vector_map #(
  parameter int PIN_COUNT = ivm_pkg::PIN_COUNT_DEFAULT
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire ivm_pkg::ivm_src_s i_src_event,
  input wire ivm_pkg::ivm_axi_req_s i_axi,
  output ivm_pkg::ivm_axi_rsp_s o_axi,
  output logic o_irq,
  output logic o_vec_valid,
  output logic [4:0] o_vec_num,
  output logic [5:0] o_vec_addr
);
  import ivm_pkg::*;

  // Port C disappears on small packages, so its flag and enable are tied off there.
  localparam logic [30:0] SRC_AVAIL = (PIN_COUNT >= PORTC_MIN_PINS) ? FLAG_MASK :
                                      (FLAG_MASK & ~(31'h1 << VEC_PORTC));

  logic [30:0] src_evt;
  logic gie_q;
  logic [30:0] en_q;
  logic [30:0] pend_q;
  logic [30:0] gated;
  logic sel_valid;
  logic [4:0] sel_num;
  logic vec_valid_q;
  logic [4:0] vec_num_q;
  logic [5:0] vec_addr_q;

  logic aw_held_q;
  logic [7:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  logic awready;
  logic wready;
  logic arready;
  logic aw_fire;
  logic w_fire;
  logic wr_go;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] wr_mask;
  logic [31:0] wr_bits;
  logic wr_hit;
  logic [30:0] pend_clr;
  logic [31:0] rd_data;
  logic rd_hit;

  // Bit position in the source struct is the vector number, so the table is a plain cast.
  assign src_evt = i_src_event & SRC_AVAIL;

  function automatic logic [31:0] ivm_byte_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  // Write channel: address and data are taken independently and joined once both are here.
  assign awready = ~aw_held_q & ~bvalid_q;
  assign wready = ~w_held_q & ~bvalid_q;
  assign aw_fire = i_axi.awvalid & awready;
  assign w_fire = i_axi.wvalid & wready;
  assign wr_go = (aw_held_q | aw_fire) & (w_held_q | w_fire) & ~bvalid_q;
  assign wr_addr = aw_held_q ? aw_addr_q : i_axi.awaddr[7:0];
  assign wr_data = w_held_q ? w_data_q : i_axi.wdata;
  assign wr_strb = w_held_q ? w_strb_q : i_axi.wstrb;
  assign wr_mask = ivm_byte_mask(wr_strb);
  assign wr_bits = wr_data & wr_mask;
  assign wr_hit = (wr_addr == REG_CTRL) || (wr_addr == REG_PEND) || (wr_addr == REG_ENABLE) ||
                  (wr_addr == REG_VECTOR) || (wr_addr == REG_REQ);

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end else if (aw_fire) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= i_axi.awaddr[7:0];
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      w_held_q <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end else if (w_fire) begin
      w_held_q <= 1'b1;
      w_data_q <= i_axi.wdata;
      w_strb_q <= i_axi.wstrb;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_axi.bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // Global enable; only the low byte lane carries it.
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      gie_q <= GIE_RST;
    end else if (wr_go && wr_addr == REG_CTRL && wr_strb[0]) begin
      gie_q <= wr_data[CTRL_GIE_BIT];
    end
  end

  // Source enables; reset entry and the non-maskable vector have no enable bit.
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      en_q <= ENABLE_RST;
    end else if (wr_go && wr_addr == REG_ENABLE) begin
      // Strobed bytes take the written value, zeros included; unstrobed bytes keep theirs.
      en_q <= ((wr_data[30:0] & wr_mask[30:0]) | (en_q & ~wr_mask[30:0])) & ENABLE_MASK & SRC_AVAIL;
    end
  end

  // Pending flags clear only by writing ones; an event in the same cycle keeps the flag set.
  assign pend_clr = (wr_go && wr_addr == REG_PEND) ? wr_bits[30:0] : 31'h0;

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      pend_q <= PEND_RST;
    end else begin
      pend_q <= ((pend_q & ~pend_clr) | src_evt) & SRC_AVAIL;
    end
  end

  // The non-maskable request bypasses both the enable bit and the global gate.
  assign gated = (pend_q & en_q & {31{gie_q}}) | (pend_q & NMI_MASK);

  // Scanning downward leaves the lowest requesting vector as the final pick.
  always_comb begin
    sel_valid = 1'b0;
    sel_num = VEC_RESET;
    for (int i = VEC_COUNT - 1; i >= 1; i--) begin
      if (gated[i]) begin
        sel_valid = 1'b1;
        sel_num = 5'(i);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      vec_valid_q <= 1'b0;
      vec_num_q <= VEC_RESET;
      vec_addr_q <= 6'h00;
    end else begin
      vec_valid_q <= sel_valid;
      vec_num_q <= sel_num;
      vec_addr_q <= 6'(sel_num) * VEC_ADDR_STRIDE;
    end
  end

  // Read channel: one outstanding read, answered the cycle after the address is taken.
  assign arready = ~rvalid_q;

  always_comb begin
    rd_data = 32'h0;
    rd_hit = 1'b1;
    unique case (i_axi.araddr[7:0])
      REG_CTRL: rd_data = 32'(gie_q) << CTRL_GIE_BIT;
      REG_PEND: rd_data = {1'b0, pend_q};
      REG_ENABLE: rd_data = {1'b0, en_q};
      REG_VECTOR: rd_data = (32'(vec_valid_q) << VECTOR_VALID_BIT) | (32'(vec_addr_q) << VECTOR_ADDR_LSB) |
                            (32'(vec_num_q) << VECTOR_NUM_LSB);
      REG_REQ: rd_data = {1'b0, gated};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else if (i_axi.arvalid && arready) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_data;
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (i_axi.rready) begin
      rvalid_q <= 1'b0;
    end
  end

  always_comb begin
    o_axi.awready = awready;
    o_axi.wready = wready;
    o_axi.bvalid = bvalid_q;
    o_axi.bresp = bresp_q;
    o_axi.arready = arready;
    o_axi.rvalid = rvalid_q;
    o_axi.rdata = rdata_q;
    o_axi.rresp = rresp_q;
  end

  assign o_irq = vec_valid_q;
  assign o_vec_valid = vec_valid_q;
  assign o_vec_num = vec_num_q;
  assign o_vec_addr = vec_addr_q;

endmodule

/* File: inc/ivm_pkg.sv */
// Constants, register map and carrier types for the interrupt vector mapping block.
package ivm_pkg;

  localparam int VEC_COUNT = 31;
  localparam int PIN_COUNT_DEFAULT = 24;
  localparam int PORTC_MIN_PINS = 20;
  localparam logic [4:0] VEC_RESET = 5'h00;
  localparam logic [4:0] VEC_NMI = 5'h01;
  localparam logic [4:0] VEC_PORTC = 5'h05;
  localparam logic [5:0] VEC_ADDR_STRIDE = 6'h02;

  localparam logic [30:0] FLAG_MASK = 31'h7ffffffe;
  localparam logic [30:0] NMI_MASK = 31'h00000002;
  localparam logic [30:0] ENABLE_MASK = 31'h7ffffffc;
  localparam logic [30:0] PEND_RST = 31'h00000000;
  localparam logic [30:0] ENABLE_RST = 31'h00000000;
  localparam logic GIE_RST = 1'b0;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PEND = 8'h04;
  localparam logic [7:0] REG_ENABLE = 8'h08;
  localparam logic [7:0] REG_VECTOR = 8'h0c;
  localparam logic [7:0] REG_REQ = 8'h10;
  localparam int CTRL_GIE_BIT = 0;
  localparam int VECTOR_VALID_BIT = 31;
  localparam int VECTOR_ADDR_LSB = 8;
  localparam int VECTOR_NUM_LSB = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bit position of each field equals its vector number; the first field is bit 30.
  typedef struct packed {
    logic nvm_eeprom_ready;
    logic transmit_complete;
    logic transmit_buffer_empty;
    logic receive_complete;
    logic spi_request;
    logic two_wire_master_request;
    logic two_wire_slave_request;
    logic adc1_window_compare;
    logic adc1_result_available;
    logic adc0_window_compare;
    logic adc0_result_available;
    logic comparator2;
    logic comparator1;
    logic comparator0;
    logic control_timer_trigger;
    logic control_timer_overflow_event;
    logic capture_timer1;
    logic capture_timer0;
    logic compare_channel_two;
    logic compare_channel_one;
    logic compare_channel_zero;
    logic high_underflow;
    logic low_underflow_or_overflow_event;
    logic periodic_tick;
    logic rtc_count;
    logic port_c_pin_change;
    logic port_b_pin_change;
    logic port_a_pin_change;
    logic voltage_level_monitor;
    logic scan_checksum_nmi;
    logic reset_entry_unused;
  } ivm_src_s;

  typedef struct packed {
    logic awvalid;
    logic [31:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [31:0] araddr;
    logic rready;
  } ivm_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ivm_axi_rsp_s;

endpackage

/* File: test/ivm_cpu_model.sv */
// Behavioural CPU core that fetches the presented interrupt vector word.
`timescale 1ns/1ps
module ivm_cpu_model (
  input wire logic i_mclk,
  input wire logic i_irq,
  input wire logic [5:0] i_vec_addr,
  output logic [5:0] o_fetch_addr
);
  // The core never acknowledges, so it simply refetches while a request stands.
  always @(posedge i_mclk) begin
    if (i_irq) begin
      o_fetch_addr <= i_vec_addr;
    end
  end
endmodule

/* File: test/ivm_vector_map_properties.sv */
// Checker of the vector outputs and register bus handshakes.
`timescale 1ns/1ps
module ivm_vector_map_properties #(
  parameter int PIN_COUNT = 24
) (
  input wire logic i_mclk,
  input wire logic i_nrst,
  input wire ivm_pkg::ivm_src_s i_src_event,
  input wire ivm_pkg::ivm_axi_req_s i_axi,
  input wire ivm_pkg::ivm_axi_rsp_s o_axi,
  input wire logic o_irq,
  input wire logic o_vec_valid,
  input wire logic [4:0] o_vec_num,
  input wire logic [5:0] o_vec_addr
);
  import ivm_pkg::*;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  AST_ADDR: assert property (o_vec_addr == {o_vec_num, 1'b0}) else $error("vector address wrong");
  AST_RANGE: assert property (o_vec_valid |-> o_vec_num inside {[1:30]}) else $error("vector out of range");
  AST_IRQ: assert property ($rose(o_irq) |-> ($past(i_src_event, 2) != '0) || $past(i_axi.wvalid, 2))
    else $error("request raised without a flag or a write");
  AST_NMI: assert property (i_src_event[1] |-> ##[1:3] (o_vec_valid && o_vec_num == VEC_NMI))
    else $error("checksum request not presented");
  AST_HOLD: assert property ($fell(o_vec_valid) |-> $past(i_axi.wvalid, 2) || $past(i_axi.wvalid, 3))
    else $error("request cleared itself");
  AST_PORTC: assert property (PIN_COUNT < PORTC_MIN_PINS |-> !(o_vec_valid && o_vec_num == VEC_PORTC))
    else $error("port C vector on small part");
  AST_BSTAY: assert property (o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp))
    else $error("write answer dropped");
  AST_RSTAY: assert property (o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata))
    else $error("read answer dropped");
  AST_BLAT: assert property (i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready |=> o_axi.bvalid)
    else $error("write answer late");
  AST_RLAT: assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid) else $error("read answer late");
  cover property (o_vec_valid && o_vec_num == 5'h1e);
  cover property ($fell(o_vec_valid));
  cover property (o_axi.rvalid && o_axi.rresp == RESP_SLVERR);
endmodule

bind ivm_vector_map ivm_vector_map_properties #(.PIN_COUNT(PIN_COUNT)) u_props (.i_mclk(i_mclk), .i_nrst(i_nrst),
  .i_src_event(i_src_event), .i_axi(i_axi), .o_axi(o_axi), .o_irq(o_irq), .o_vec_valid(o_vec_valid),
  .o_vec_num(o_vec_num), .o_vec_addr(o_vec_addr));

/* File: test/ivm_vector_map_tb_top.sv */
// Self-checking bench for the interrupt vector mapping block.
`timescale 1ns/1ps
module ivm_vector_map_tb_top;
  import ivm_pkg::*;
  logic i_mclk = 0;
  logic i_nrst = 0;
  ivm_src_s ev = '0;
  ivm_axi_req_s req = '0;
  ivm_axi_rsp_s rsp;
  logic irq, vv;
  logic [4:0] vn;
  logic [5:0] va, fa;
  logic [31:0] rd, pend, en;
  logic [1:0] rr;
  logic gie;
  logic [3:0] strb = 4'hf;
  logic irq_s, vv_s;
  logic [4:0] vn_s;
  logic [5:0] va_s;
  int n_errors = 0;
  int samples_checked = 0;
  integer seed = 32'h8e01;
  always #2.5 i_mclk = ~i_mclk;
  ivm_vector_map #(.PIN_COUNT(24)) uut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_src_event(ev), .i_axi(req),
    .o_axi(rsp), .o_irq(irq), .o_vec_valid(vv), .o_vec_num(vn), .o_vec_addr(va));
  // A small package variant shares all stimulus; only its port C vector must stay silent.
  ivm_vector_map #(.PIN_COUNT(PORTC_MIN_PINS - 1)) uut_small (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_src_event(ev),
    .i_axi(req), .o_axi(), .o_irq(irq_s), .o_vec_valid(vv_s), .o_vec_num(vn_s), .o_vec_addr(va_s));
  ivm_cpu_model cpu (.i_mclk(i_mclk), .i_irq(irq), .i_vec_addr(va), .o_fetch_addr(fa));
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  // One bus transfer; every channel is held until its own ready is seen at an edge.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge i_mclk);
    req <= '{wr, {24'h0, a}, wr, d, strb, wr, !wr, {24'h0, a}, !wr};
    for (t = 0; t < 40; t++) begin
      @(posedge i_mclk);
      if ((wr && rsp.bvalid) || (!wr && rsp.rvalid)) break;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      if (rsp.arready) req.arvalid <= 1'b0;
    end
    rd = rsp.rdata;
    rr = wr ? rsp.bresp : rsp.rresp;
    req <= '0;
    if (t == 40) begin
      n_errors++;
      $display("ERROR bus expected answer seen none");
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    chk("bresp", RESP_OKAY, rr);
    repeat (2) @(posedge i_mclk);
  endtask
  task automatic pulse(input logic [31:0] m);
    @(posedge i_mclk);
    ev <= m[30:0] & FLAG_MASK;
    pend = pend | (m & {1'b0, FLAG_MASK});
    @(posedge i_mclk);
    ev <= '0;
    repeat (2) @(posedge i_mclk);
  endtask
  task automatic check_vec();
    logic [31:0] g;
    logic [31:0] gs;
    int k;
    int ks;
    g = (pend & en & {32{gie}}) | (pend & 32'h2);
    gs = g & ~(32'h1 << VEC_PORTC);
    k = 0;
    ks = 0;
    for (int i = 30; i >= 1; i--) begin
      if (g[i]) k = i;
      if (gs[i]) ks = i;
    end
    bus(1'b0, REG_REQ, 32'h0);
    chk("req_reg", g, rd);
    chk("irq", g != 0, irq);
    chk("vec_valid", g != 0, vv);
    chk("vec_num", k, vn);
    chk("vec_addr", 2 * k, va);
    if (g != 0) chk("fetch_addr", 2 * k, fa);
    chk("vec_valid_small", gs != 0, vv_s);
    chk("vec_num_small", ks, vn_s);
    chk("irq_small", gs != 0, irq_s);
    chk("vec_addr_small", 2 * ks, va_s);
    bus(1'b0, REG_VECTOR, 32'h0);
    chk("vector_reg", (32'(g != 0) << VECTOR_VALID_BIT) | (32'(2 * k) << VECTOR_ADDR_LSB) | 32'(k), rd);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    pend = 0;
    en = 0;
    gie = 0;
    repeat (6) @(posedge i_mclk);
    i_nrst <= 1'b1;
    for (int a = 0; a < 24; a += 4) begin
      bus(1'b0, a[7:0], 32'h0);
      chk("reset_read", 0, rd);
      chk("rresp", a == 20 ? RESP_SLVERR : RESP_OKAY, rr);
    end
    bus(1'b1, 8'h14, 32'hffffffff);
    chk("bresp_unmapped", RESP_SLVERR, rr);
    wreg(REG_ENABLE, 32'hffffffff);
    en = {1'b0, ENABLE_MASK};
    bus(1'b0, REG_ENABLE, 32'h0);
    chk("enable_read", en, rd);
    strb = 4'h1;
    wreg(REG_ENABLE, 32'h0);
    strb = 4'hf;
    bus(1'b0, REG_ENABLE, 32'h0);
    chk("enable_strobe", en & 32'hffffff00, rd);
    wreg(REG_ENABLE, 32'hffffffff);
    wreg(REG_CTRL, 32'h1);
    gie = 1;
    $display("test registers done");
    for (int n = 1; n <= 30; n++) begin
      pulse(32'h1 << n);
      check_vec();
      wreg(REG_PEND, 32'h1 << n);
      pend = 0;
      check_vec();
    end
    $display("test vector walk done");
    for (int i = 0; i < 12; i++) begin
      en = $random(seed) & {1'b0, ENABLE_MASK};
      gie = i[0];
      wreg(REG_ENABLE, en);
      wreg(REG_CTRL, {31'h0, gie});
      pulse($random(seed));
      check_vec();
      wreg(REG_PEND, 32'h7fffffff);
      pend = 0;
      check_vec();
    end
    $display("test random priority done");
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge i_mclk);
    $display("ERROR watchdog expected finish seen timeout");
    n_errors++;
    end_sim();
  end
endmodule
